// ==== hdl/exs_regs.svh ====
`ifndef EXS_REGS_SVH
`define EXS_REGS_SVH
// Register byte offsets on the APB side
`define EXS_A_CTRL   8'h00
`define EXS_A_SR     8'h04
`define EXS_A_MSP    8'h08
`define EXS_A_ISP    8'h0c
`define EXS_A_VBR    8'h10
`define EXS_A_PC     8'h14
`define EXS_A_SSR    8'h18
`define EXS_A_INFO   8'h1c
`define EXS_A_ISTAT  8'h20
`define EXS_A_IMASK  8'h24
// Status register fields
`define EXS_SR_T1    15
`define EXS_SR_T0    14
`define EXS_SR_S     13
`define EXS_SR_M     12
`define EXS_IPM_HI   10
`define EXS_IPM_LO   8
`define EXS_SR_RST   16'h2700
`define EXS_IPM_MAX  3'h7
// Control register
`define EXS_CTRL_IEN 0
`define EXS_CTRL_RST 1'h1
// Vector numbers produced internally
`define EXS_V_RESET  8'h01
`define EXS_V_BUS_FAULT_INPUT   8'h02
`define EXS_V_ADDR   8'h03
`define EXS_V_ILL    8'h04
`define EXS_V_DIV    8'h05
`define EXS_V_CHK    8'h06
`define EXS_V_CONDITIONAL_TRAP_INSTR 8'h07
`define EXS_V_PRIV   8'h08
`define EXS_V_TRACE  8'h09
`define EXS_V_BKPT   8'h0c
`define EXS_V_TRAP0  8'h20
// Frame formats and lengths in long words
`define EXS_FMT_SHORT 4'h0
`define EXS_FMT_LONG  4'h2
`define EXS_LEN_SHORT 3'h2
`define EXS_LEN_LONG  3'h4
// Interrupt acknowledge address space base
`define EXS_IACK_BASE 32'hfffffff0
// Event bits of the interrupt status register
`define EXS_EV_ACC   0
`define EXS_EV_LOAD  1
`define EXS_EV_HALT  2
`define EXS_EV_W     3
`endif

// ==== hdl/exs_pkg.sv ====
package exs_pkg;
	// Sequencer states, one-hot
	typedef enum logic [6:0] {
		EXS_IDLE  = 7'h01,
		EXS_SAVE  = 7'h02,
		EXS_VECT  = 7'h04,
		EXS_STACK = 7'h08,
		EXS_FETCH = 7'h10,
		EXS_LOAD  = 7'h20,
		EXS_HALT  = 7'h40
	} exs_state_t;
	// Internal causes, highest priority first
	typedef struct packed {
		logic addr_err;
		logic odd_fetch;
		logic trace;
		logic illegal;
		logic bkpt;
		logic priv;
		logic divz;
		logic bounds;
		logic cond_trap;
		logic ovf_trap;
		logic cp_trap;
		logic trap;
	} exs_cause_t;
	// Memory request carried to the bus unit
	typedef struct packed {
		logic        we;
		logic        iack;
		logic [31:0] addr;
		logic [31:0] wdata;
	} exs_mem_t;
endpackage

// ==== hdl/exs_sequencer.sv ====
`timescale 1ns/1ps
`include "exs_regs.svh"
module exs_sequencer (
	input  wire logic             i_clk_sys,       // System clock
	input  wire logic             i_resetn,        // Async reset, low
	input  wire logic             i_clk_en,        // Freezes all state when low
	input  wire logic             i_psel,          // APB select
	input  wire logic             i_penable,       // APB enable
	input  wire logic             i_pwrite,        // APB write
	input  wire logic [7:0]       i_paddr,         // APB byte address
	input  wire logic [31:0]      i_pwdata,        // APB write data
	output logic      [31:0]      o_prdata,        // APB read data
	output logic                  o_pready,        // APB ready
	output logic                  o_pslverr,       // APB error, unmapped
	output logic                  o_irq,           // Level interrupt
	input  wire logic [2:0]       i_irq_level,     // Peripheral request level
	input  wire logic             i_bus_fault,     // Bus fault input
	input  wire logic             i_reset_exc,     // Reset exception request
	input  wire exs_pkg::exs_cause_t i_cause,      // Internal cause pulses
	input  wire logic [3:0]       i_trap_num,      // Trap number with trap
	input  wire logic             i_cp_exc,        // Coprocessor exception
	input  wire logic [7:0]       i_cp_vec,        // Coprocessor vector number
	input  wire logic [31:0]      i_cur_pc,        // PC of faulting point
	input  wire logic [31:0]      i_fault_addr,    // Faulting address
	input  wire logic             i_instr_boundary,// Instruction boundary pulse
	input  wire logic             i_pipe_refill,   // Pipeline refill pulse
	output logic                  o_mem_req,       // Memory request level
	output exs_pkg::exs_mem_t     o_mem,           // Memory request fields
	input  wire logic             i_mem_ack,       // Memory answer
	input  wire logic             i_mem_err,       // Fault on memory answer
	input  wire logic [31:0]      i_mem_rdata,     // Memory read data
	output logic      [31:0]      o_pc,            // Program counter
	output logic                  o_pc_load,       // PC loaded pulse
	output logic      [15:0]      o_sr,            // Status register
	output logic                  o_status,        // Sequencer status
	output logic                  o_refill         // Pipe refill indicator
);
	import exs_pkg::*;

	exs_state_t  st_r;
	exs_cause_t  pend_r;
	logic        bus_fault_input_p_r, cp_p_r;
	logic [7:0]  cp_vec_r;
	logic [3:0]  trap_num_r;
	logic [15:0] sr_r, ssr_r;
	logic [31:0] msp_r, isp_r, vbr_r, pc_r;
	logic [31:0] pcsv_r, fault_r;
	logic [7:0]  vec_r;
	logic [2:0]  lvl_r, idx_r;
	logic        irq_k_r, rst_k_r, long_r, use_msp_r, dup_r;
	logic        ctrl_ien_r;
	logic [`EXS_EV_W-1:0] stat_r, mask_r;

	// Top set bit of the cause vector, so one cause is served at a time
	function automatic logic [11:0] exs_top(input logic [11:0] v);
		logic [11:0] r;
		r = 12'h000;
		for (int i = 0; i < 12; i++) begin
			if (v[i]) begin
				r = 12'h001 << i;
			end
		end
		return r;
	endfunction

	// Internal vector number for a one-hot cause
	function automatic logic [7:0] exs_vec(input logic [11:0] oh, input logic [3:0] tn);
		logic [7:0] r;
		r = `EXS_V_ILL;
		case (1'b1)
			oh[11], oh[10]: r = `EXS_V_ADDR;
			oh[9]:          r = `EXS_V_TRACE;
			oh[8]:          r = `EXS_V_ILL;
			oh[7]:          r = `EXS_V_BKPT;
			oh[6]:          r = `EXS_V_PRIV;
			oh[5]:          r = `EXS_V_DIV;
			oh[4]:          r = `EXS_V_CHK;
			oh[3], oh[2], oh[1]: r = `EXS_V_CONDITIONAL_TRAP_INSTR;
			oh[0]:          r = `EXS_V_TRAP0 + {4'h0, tn};
			default:        r = `EXS_V_ILL;
		endcase
		return r;
	endfunction

	// One long word of the frame; long frames add fault data
	function automatic logic [31:0] exs_frame(input logic [2:0] i, input logic [15:0] sr,
			input logic [31:0] pc, input logic lng, input logic [7:0] v, input logic [31:0] fa);
		logic [31:0] r;
		case (i)
			3'h0:    r = {sr, pc[31:16]};
			3'h1:    r = {pc[15:0], (lng ? `EXS_FMT_LONG : `EXS_FMT_SHORT), 2'h0, v, 2'h0};
			3'h2:    r = fa;
			default: r = {24'h0, v};
		endcase
		return r;
	endfunction

	// Cause selection; trace and faults sit above interrupts
	wire [11:0] pv      = pend_r;
	wire        hi_any  = |pv[11:9];
	wire        lo_any  = |pv[8:0];
	wire        irq_ok  = ctrl_ien_r && (i_irq_level > sr_r[`EXS_IPM_HI:`EXS_IPM_LO]);
	wire        t_bus_fault_input  = bus_fault_input_p_r;
	wire        t_hi    = !t_bus_fault_input && hi_any;
	wire        t_irq   = !t_bus_fault_input && !hi_any && irq_ok;
	wire        t_cp    = !t_bus_fault_input && !hi_any && !irq_ok && cp_p_r;
	wire        t_lo    = !t_bus_fault_input && !hi_any && !irq_ok && !cp_p_r && lo_any;
	wire        idle    = (st_r == EXS_IDLE);
	wire        take    = idle && (t_bus_fault_input || t_hi || t_irq || t_cp || t_lo);
	wire [11:0] top     = exs_top(pv);
	wire [11:0] clr     = (take && (t_hi || t_lo)) ? top : 12'h000;
	wire [7:0]  sel_vec = t_bus_fault_input ? `EXS_V_BUS_FAULT_INPUT :
	                      t_cp ? cp_vec_r :
	                      exs_vec(top, trap_num_r);
	wire        sel_lng = t_bus_fault_input || (t_hi && (top[11] || top[10]));

	// Stack addressing for the frame being written
	wire [31:0] sp_cur  = use_msp_r ? msp_r : isp_r;
	wire [2:0]  nlong   = long_r ? `EXS_LEN_LONG : `EXS_LEN_SHORT;
	wire [31:0] fr_base = sp_cur - {27'h0, nlong, 2'h0};
	wire [31:0] fr_addr = fr_base + {27'h0, idx_r, 2'h0};
	wire        fr_last = (idx_r == (nlong - 3'h1));
	wire [31:0] vec_adr = vbr_r + {22'h0, vec_r, 2'h0};
	wire        op_done = o_mem_req && i_mem_ack;
	wire        dbl_flt = (!idle && (i_bus_fault || (op_done && i_mem_err)));

	// APB decode; one wait-free access phase after setup
	wire        apb_set = i_psel && !i_penable;
	wire        apb_wr  = i_psel && i_penable && i_pwrite && o_pready;
	wire        h_ctrl  = (i_paddr == `EXS_A_CTRL);
	wire        h_sr    = (i_paddr == `EXS_A_SR);
	wire        h_msp   = (i_paddr == `EXS_A_MSP);
	wire        h_isp   = (i_paddr == `EXS_A_ISP);
	wire        h_vbr   = (i_paddr == `EXS_A_VBR);
	wire        h_pc    = (i_paddr == `EXS_A_PC);
	wire        h_ssr   = (i_paddr == `EXS_A_SSR);
	wire        h_info  = (i_paddr == `EXS_A_INFO);
	wire        h_ist   = (i_paddr == `EXS_A_ISTAT);
	wire        h_imk   = (i_paddr == `EXS_A_IMASK);
	wire        hit     = h_ctrl | h_sr | h_msp | h_isp | h_vbr | h_pc | h_ssr | h_info | h_ist | h_imk;
	wire [31:0] rd_mux  = h_ctrl ? {31'h0, ctrl_ien_r} :
	                      h_sr   ? {16'h0, sr_r} :
	                      h_msp  ? msp_r :
	                      h_isp  ? isp_r :
	                      h_vbr  ? vbr_r :
	                      h_pc   ? pc_r :
	                      h_ssr  ? {16'h0, ssr_r} :
	                      h_info ? {17'h0, st_r, vec_r} :
	                      h_ist  ? {29'h0, stat_r} :
	                      h_imk  ? {29'h0, mask_r} : 32'h0;

	// Sticky events; a new event wins over a write-one clear
	wire [`EXS_EV_W-1:0] ev = {(st_r != EXS_HALT) && dbl_flt, (st_r == EXS_LOAD), take};
	wire [`EXS_EV_W-1:0] w1c = (apb_wr && h_ist) ? i_pwdata[`EXS_EV_W-1:0] : 3'h0;
	wire [`EXS_EV_W-1:0] stat_nxt = (stat_r & ~w1c) | ev;

	// APB slave handshake and read data capture
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h0;
		end else if (i_clk_en) begin
			o_pready  <= apb_set;
			o_pslverr <= apb_set && !hit;
			o_prdata  <= apb_set ? rd_mux : o_prdata;
		end
	end

	// Control, event and mask registers and the interrupt line
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			ctrl_ien_r <= `EXS_CTRL_RST;
			stat_r     <= 3'h0;
			mask_r     <= 3'h0;
			o_irq      <= 1'b0;
		end else if (i_clk_en) begin
			if (apb_wr && h_ctrl) begin
				ctrl_ien_r <= i_pwdata[`EXS_CTRL_IEN];
			end
			if (apb_wr && h_imk) begin
				mask_r <= i_pwdata[`EXS_EV_W-1:0];
			end
			stat_r <= stat_nxt;
			o_irq  <= |(stat_r & mask_r);
		end
	end

	// Pending causes; an arrival in the serving cycle is kept
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			pend_r     <= '0;
			bus_fault_input_p_r   <= 1'b0;
			cp_p_r     <= 1'b0;
			cp_vec_r   <= 8'h0;
			trap_num_r <= 4'h0;
		end else if (i_clk_en) begin
			pend_r   <= (pend_r & ~clr) | i_cause;
			bus_fault_input_p_r <= (bus_fault_input_p_r && !(take && t_bus_fault_input)) || (i_bus_fault && idle);
			cp_p_r   <= (cp_p_r && !(take && t_cp)) || i_cp_exc;
			if (i_cp_exc) begin
				cp_vec_r <= i_cp_vec;
			end
			if (i_cause.trap) begin
				trap_num_r <= i_trap_num;
			end
		end
	end

	// Five-step sequencer with status, stack pointers and PC
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			st_r <= EXS_IDLE;
			sr_r <= `EXS_SR_RST;
			ssr_r <= 16'h0;
			msp_r <= 32'h0;
			isp_r <= 32'h0;
			vbr_r <= 32'h0;
			pc_r <= 32'h0;
			pcsv_r <= 32'h0;
			fault_r <= 32'h0;
			vec_r <= 8'h0;
			lvl_r <= 3'h0;
			idx_r <= 3'h0;
			irq_k_r <= 1'b0;
			rst_k_r <= 1'b0;
			long_r <= 1'b0;
			use_msp_r <= 1'b0;
			dup_r <= 1'b0;
			o_mem_req <= 1'b0;
			o_mem <= '0;
			o_pc_load <= 1'b0;
		end else if (i_clk_en) begin
			o_pc_load <= 1'b0;
			if (apb_wr && h_sr) sr_r <= i_pwdata[15:0];
			if (apb_wr && h_msp) msp_r <= i_pwdata;
			if (apb_wr && h_isp) isp_r <= i_pwdata;
			if (apb_wr && h_vbr) vbr_r <= i_pwdata;
			if (apb_wr && h_pc) pc_r <= i_pwdata;
			if (i_reset_exc) begin
				st_r      <= EXS_SAVE;
				rst_k_r   <= 1'b1;
				irq_k_r   <= 1'b0;
				vec_r     <= `EXS_V_RESET;
				o_mem_req <= 1'b0;
			end else begin
				case (st_r)
					EXS_IDLE: begin
						if (take) begin
							st_r    <= EXS_SAVE;
							rst_k_r <= 1'b0;
							irq_k_r <= t_irq;
							lvl_r   <= i_irq_level;
							vec_r   <= sel_vec;
							long_r  <= sel_lng;
							pcsv_r  <= i_cur_pc;
							fault_r <= i_fault_addr;
						end
					end
					EXS_SAVE: begin
						ssr_r <= sr_r;
						sr_r[`EXS_SR_S]  <= 1'b1;
						sr_r[`EXS_SR_T1] <= 1'b0;
						sr_r[`EXS_SR_T0] <= 1'b0;
						if (rst_k_r || irq_k_r) begin
							sr_r[`EXS_SR_M] <= 1'b0;
							sr_r[`EXS_IPM_HI:`EXS_IPM_LO] <= rst_k_r ? `EXS_IPM_MAX : lvl_r;
						end
						use_msp_r <= sr_r[`EXS_SR_M] && !rst_k_r;
						dup_r     <= sr_r[`EXS_SR_M] && irq_k_r;
						idx_r     <= 3'h0;
						st_r      <= EXS_VECT;
					end
					EXS_VECT: begin
						if (!irq_k_r) begin
							st_r <= rst_k_r ? EXS_FETCH : EXS_STACK;
						end else if (!o_mem_req) begin
							o_mem_req <= 1'b1;
							o_mem     <= '{we: 1'b0, iack: 1'b1,
							               addr: `EXS_IACK_BASE | {28'h0, lvl_r, 1'b0}, wdata: 32'h0};
						end else if (op_done) begin
							o_mem_req <= 1'b0;
							vec_r     <= i_mem_rdata[7:0];
							st_r      <= EXS_STACK;
						end
					end
					EXS_STACK: begin
						if (!o_mem_req) begin
							o_mem_req <= 1'b1;
							o_mem     <= '{we: 1'b1, iack: 1'b0, addr: fr_addr,
							               wdata: exs_frame(idx_r, ssr_r, pcsv_r, long_r, vec_r, fault_r)};
						end else if (op_done) begin
							o_mem_req <= 1'b0;
							idx_r     <= idx_r + 3'h1;
							if (fr_last) begin
								idx_r <= 3'h0;
								if (use_msp_r) msp_r <= fr_base;
								else isp_r <= fr_base;
								if (dup_r) begin
									dup_r     <= 1'b0;
									use_msp_r <= 1'b0;
								end else begin
									st_r <= EXS_FETCH;
								end
							end
						end
					end
					EXS_FETCH: begin
						if (!o_mem_req) begin
							o_mem_req <= 1'b1;
							o_mem     <= '{we: 1'b0, iack: 1'b0, addr: vec_adr, wdata: 32'h0};
						end else if (op_done) begin
							o_mem_req <= 1'b0;
							pc_r      <= i_mem_rdata;
							st_r      <= EXS_LOAD;
						end
					end
					EXS_LOAD: begin
						o_pc_load <= 1'b1;
						st_r      <= EXS_IDLE;
					end
					EXS_HALT: begin
						st_r <= EXS_HALT;
					end
					default: begin
						st_r <= EXS_IDLE;
					end
				endcase
				// A fault while the sequence runs stops the sequencer
				if (dbl_flt) begin
					st_r      <= EXS_HALT;
					o_mem_req <= 1'b0;
				end
			end
		end
	end

	// Indicators follow sequencer state and the boundary and refill pulses, never bus handshakes
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_status <= 1'b0;
			o_refill <= 1'b0;
		end else if (i_clk_en) begin
			o_status <= i_instr_boundary || take || (st_r == EXS_HALT);
			o_refill <= i_pipe_refill || (st_r == EXS_LOAD);
		end
	end

	assign o_pc = pc_r;
	assign o_sr = sr_r;

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_resetn || !i_clk_en || i_reset_exc);

	sequence s_fetch_done;
		(st_r == EXS_FETCH) && op_done && !i_mem_err && !i_bus_fault;
	endsequence
	sequence s_loaded;
		(st_r == EXS_LOAD) ##1 (o_pc_load && o_refill);
	endsequence

	chk_accept_save: assert property (take |=> st_r == EXS_SAVE)
		else $error("accepted exception did not enter save step");
	chk_sbit_trace: assert property ((st_r == EXS_SAVE) |=> sr_r[`EXS_SR_S] && !sr_r[`EXS_SR_T1] && !sr_r[`EXS_SR_T0])
		else $error("supervisor or trace bits wrong after save");
	chk_sr_copy: assert property ((st_r == EXS_SAVE) |=> ssr_r == $past(sr_r))
		else $error("saved status differs from pre-exception status");
	chk_irq_mask: assert property ((st_r == EXS_SAVE) && irq_k_r |=> sr_r[`EXS_IPM_HI:`EXS_IPM_LO] == lvl_r && !sr_r[`EXS_SR_M])
		else $error("interrupt mask or master bit not updated");
	chk_iack_read: assert property (o_mem_req && o_mem.iack |-> !o_mem.we && irq_k_r && st_r == EXS_VECT)
		else $error("acknowledge cycle outside interrupt vector step");
	chk_vec_addr: assert property ((st_r == EXS_FETCH) && o_mem_req |-> o_mem.addr == vbr_r + {22'h0, vec_r, 2'h0})
		else $error("vector fetch address wrong");
	chk_pc_load: assert property (s_fetch_done |=> s_loaded)
		else $error("fetched vector not loaded into program counter");
	chk_reset_noframe: assert property ((st_r == EXS_SAVE) && rst_k_r |=> (st_r == EXS_VECT) ##1 (st_r == EXS_FETCH))
		else $error("reset exception stacked a frame");
	chk_no_accept: assert property (!idle |=> st_r != EXS_SAVE)
		else $error("exception accepted while sequence runs");
	chk_halt_status: assert property ((st_r == EXS_HALT) |=> o_status)
		else $error("halted sequencer not shown on status");
endmodule // exs_sequencer

// ==== tb/exs_mem_model.sv ====
`timescale 1ns/1ps
module exs_mem_model
	import exs_pkg::*;
(
	input  wire logic     i_clk_sys,   // Clock
	input  wire logic     i_resetn,    // Reset, low
	input  wire logic     i_req,       // Request level
	input  wire exs_mem_t i_mem,       // Request fields
	input  wire logic [7:0] i_vec,     // Vector for acknowledge reads
	output logic          o_ack,       // Answer pulse
	output logic          o_err,       // Fault answer, never raised
	output logic [31:0]   o_rdata,     // Read data
	output logic [31:0]   o_last_rd,   // Last vector fetch address
	output logic [31:0]   o_iack_addr, // Last acknowledge address
	output logic [7:0]    o_wr_cnt     // Frame writes taken
);
	logic [1:0] wait_r; // Delay before the next answer
	logic       slow_r; // Alternates prompt and slow answers
	assign o_err = 1'b0;
	// Answer a held request; read data is scrambled on every edge that gives no answer
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_ack <= 1'b0;
			wait_r <= 2'h0;
			slow_r <= 1'b0;
			o_rdata <= 32'h0;
			o_last_rd <= 32'h0;
			o_iack_addr <= 32'h0;
			o_wr_cnt <= 8'h0;
		end else if (o_ack || !i_req) begin
			o_ack <= 1'b0;
			o_rdata <= ~o_rdata;
		end else if (wait_r != 2'h0) begin
			wait_r <= wait_r - 2'h1;
			o_rdata <= ~o_rdata;
		end else begin
			o_ack <= 1'b1;
			slow_r <= ~slow_r;
			wait_r <= slow_r ? 2'h0 : 2'h2;
			if (i_mem.we) begin
				o_wr_cnt <= o_wr_cnt + 8'h1;
			end else if (i_mem.iack) begin
				o_iack_addr <= i_mem.addr;
				o_rdata <= {24'h0, i_vec};
			end else begin
				o_last_rd <= i_mem.addr;
				o_rdata <= i_mem.addr + 32'h1000;
			end
		end
	end
endmodule // exs_mem_model

// ==== tb/tb_exception_sequencer.sv ====
`timescale 1ns/1ps
`include "exs_regs.svh"
module tb_exception_sequencer;
	import exs_pkg::*;
	logic clk, rstn, psel, pen, pwr, pready, slverr, pslverr, irq, bfault, rexc, cp_exc, bound, rfl_in;
	logic mreq, ack, merr, pc_load, status, refill, cen;
	logic [2:0] irq_lvl;
	logic [3:0] trap_num;
	logic [7:0] paddr, cp_vec, wr_cnt;
	logic [15:0] sr;
	logic [31:0] pwdata, prdata, rdata, pc, last_rd, iack_addr, rd;
	exs_cause_t cause;
	exs_mem_t mem;
	int err_count, check_count;
	logic [7:0] vtab [0:12] = '{8'h2f, 8'h07, 8'h07, 8'h07, 8'h06, 8'h05, 8'h08, 8'h0c, 8'h04, 8'h09, 8'h03, 8'h03, 8'h02};
	exs_sequencer dut (.i_clk_sys(clk), .i_resetn(rstn), .i_clk_en(cen), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .o_irq(irq), .i_irq_level(irq_lvl), .i_bus_fault(bfault), .i_reset_exc(rexc),
		.i_cause(cause), .i_trap_num(trap_num), .i_cp_exc(cp_exc), .i_cp_vec(cp_vec), .i_cur_pc(32'h100),
		.i_fault_addr(32'h44), .i_instr_boundary(bound), .i_pipe_refill(rfl_in), .o_mem_req(mreq), .o_mem(mem),
		.i_mem_ack(ack), .i_mem_err(merr), .i_mem_rdata(rdata), .o_pc(pc), .o_pc_load(pc_load), .o_sr(sr),
		.o_status(status), .o_refill(refill));
	exs_mem_model mdl (.i_clk_sys(clk), .i_resetn(rstn), .i_req(mreq), .i_mem(mem), .i_vec(8'h40), .o_ack(ack),
		.o_err(merr), .o_rdata(rdata), .o_last_rd(last_rd), .o_iack_addr(iack_addr), .o_wr_cnt(wr_cnt));
	// Free-running 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic hang(input string what);
		err_count++;
		$display("unexpected wait on %s: expected an answer, seen none", what);
		wrap_up();
	endtask
	// APB transfer; request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		// Sample the answer at the rising edge itself; the design updates it by NBA
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (n == 20) hang("apb");
		rd = prdata;
		slverr = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(what, rd, exp);
	endtask
	// Raise one exception kind, wait for the new PC, judge the bus traffic
	task automatic exc(input int kind, input logic [7:0] vec, input logic [7:0] nw);
		logic [7:0] w0;
		int n;
		w0 = wr_cnt;
		@(posedge clk);
		if (kind < 12) cause[kind] <= 1'b1;
		else if (kind == 12) bfault <= 1'b1;
		else if (kind == 13) cp_exc <= 1'b1;
		else if (kind == 14) rexc <= 1'b1;
		else irq_lvl <= 3'h5;
		@(posedge clk);
		cause <= '0;
		bfault <= 1'b0;
		cp_exc <= 1'b0;
		rexc <= 1'b0;
		for (n = 0; n < 300; n++) begin
			@(negedge clk);
			if (pc_load === 1'b1) break;
		end
		if (n == 300) hang("pc load");
		check("refill", {31'h0, refill}, 32'h1);
		check("frame writes", {24'h0, 8'(wr_cnt - w0)}, {24'h0, nw});
		check("vector fetch", last_rd, 32'h400 + {22'h0, vec, 2'b00});
		check("pc", pc, last_rd + 32'h1000);
		@(posedge clk);
		irq_lvl <= 3'h0;
	endtask
	task automatic scn_status_save();
		rdchk("sr reset", `EXS_A_SR, 32'h2700);
		apb(1'b0, 8'h40, 32'h0);
		check("unmapped error", {31'h0, slverr}, 32'h1);
		apb(1'b1, `EXS_A_ISP, 32'h1000);
		apb(1'b1, `EXS_A_VBR, 32'h400);
		apb(1'b1, `EXS_A_SR, 32'ha000);
		apb(1'b1, `EXS_A_IMASK, 32'h2);
		exc(8, 8'h04, 8'h2);
		check("sr after", {16'h0, sr}, 32'h2000);
		rdchk("saved sr", `EXS_A_SSR, 32'ha000);
		rdchk("isp after", `EXS_A_ISP, 32'hff8);
		check("irq set", {31'h0, irq}, 32'h1);
		apb(1'b1, `EXS_A_ISTAT, 32'h7);
		repeat (2) @(posedge clk);
		@(negedge clk);
		check("irq clear", {31'h0, irq}, 32'h0);
	endtask
	// Every internal cause, bus fault and coprocessor vector
	task automatic scn_causes();
		trap_num <= 4'hf;
		cp_vec <= 8'h38;
		for (int k = 0; k < 14; k++) begin
			exc(k, (k == 13) ? 8'h38 : vtab[k], (k > 9 && k < 13) ? 8'h4 : 8'h2);
		end
	endtask
	task automatic scn_stacks();
		apb(1'b1, `EXS_A_SR, 32'h3000);
		apb(1'b1, `EXS_A_MSP, 32'h2000);
		exc(6, 8'h08, 8'h2);
		rdchk("msp task", `EXS_A_MSP, 32'h1ff8);
		apb(1'b1, `EXS_A_SR, 32'h9200);
		apb(1'b1, `EXS_A_ISP, 32'h3000);
		exc(15, 8'h40, 8'h4);
		check("iack address", iack_addr, 32'hfffffffa);
		check("sr interrupt", {16'h0, sr}, 32'h2500);
		rdchk("msp frame", `EXS_A_MSP, 32'h1ff0);
		rdchk("isp frame", `EXS_A_ISP, 32'h2ff8);
	endtask
	// A bus fault in mid-sequence halts the sequencer until the reset exception
	task automatic scn_double_fault();
		@(posedge clk);
		cause.illegal <= 1'b1;
		@(posedge clk);
		cause <= '0;
		repeat (4) @(posedge clk);
		bfault <= 1'b1;
		@(posedge clk);
		bfault <= 1'b0;
		repeat (2) @(negedge clk);
		check("halt status", {31'h0, status}, 32'h1);
		apb(1'b0, `EXS_A_ISTAT, 32'h0);
		check("halt event", rd & 32'h4, 32'h4);
	endtask
	task automatic scn_reset_and_events();
		apb(1'b1, `EXS_A_SR, 32'h1000);
		scn_double_fault();
		exc(14, 8'h01, 8'h0);
		check("sr reset exc", {16'h0, sr}, 32'h2700);
		@(posedge clk);
		rfl_in <= 1'b1;
		bound <= 1'b1;
		@(posedge clk);
		rfl_in <= 1'b0;
		bound <= 1'b0;
		@(negedge clk);
		check("refill event", {31'h0, refill}, 32'h1);
		check("boundary event", {31'h0, status}, 32'h1);
		// A boundary pulse while the clock enable is low must not reach the indicator
		@(posedge clk);
		cen <= 1'b0;
		bound <= 1'b1;
		@(posedge clk);
		bound <= 1'b0;
		@(negedge clk);
		check("frozen status", {31'h0, status}, 32'h0);
		@(posedge clk);
		cen <= 1'b1;
	endtask
	initial begin
		{rstn, psel, pen, pwr, bfault, rexc, cp_exc, bound, rfl_in} = '0;
		{irq_lvl, trap_num, paddr, cp_vec, pwdata} = '0;
		cause = '0;
		cen = 1'b1;
		err_count = 0;
		check_count = 0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		scn_status_save();
		scn_causes();
		scn_stacks();
		scn_reset_and_events();
		wrap_up();
	end
endmodule // tb_exception_sequencer
